// ==== hdl/scc_pkg.sv ====
// Purpose: Shared constants, types and helpers for the serial calendar clock.
// Assumes: BCD time digits, with a hex month coded 1 to C.
// Notes:   The command codes and the register offsets are named here only.
package scc_pkg;

  // The crystal reference, and the prescaler value that ends one second.
  localparam int          SCC_XTAL_HZ  = 32768;
  localparam logic [14:0] SCC_PRE_LAST = 15'(SCC_XTAL_HZ - 1);
  localparam int          SCC_SR_BITS  = 40;

  // Prescaler bits that toggle at 64 Hz, 256 Hz and 2048 Hz.
  localparam int SCC_TP64_BIT   = 8;
  localparam int SCC_TP256_BIT  = 6;
  localparam int SCC_TP2048_BIT = 3;

  // Register-group commands (top code bit low).
  typedef enum logic [1:0] {
    SCC_REG_HOLD  = 2'b00,
    SCC_REG_SHIFT = 2'b01,
    SCC_REG_SET   = 2'b10,
    SCC_REG_READ  = 2'b11
  } scc_regcmd_e;

  // Pulse-group commands (top code bit high).
  typedef enum logic [1:0] {
    SCC_TP_64   = 2'b00,
    SCC_TP_256  = 2'b01,
    SCC_TP_2048 = 2'b10,
    SCC_TP_TEST = 2'b11
  } scc_tpcmd_e;

  // Wishbone byte offsets.
  localparam logic [7:0] SCC_ADR_CTRL    = 8'h00;
  localparam logic [7:0] SCC_ADR_TIME_LO = 8'h04;
  localparam logic [7:0] SCC_ADR_TIME_HI = 8'h08;
  localparam logic [7:0] SCC_ADR_STATUS  = 8'h0C;

  // Time word in shift-register order, seconds in the low bits.
  typedef struct packed {
    logic [3:0] month;
    logic [7:0] date;
    logic [3:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } scc_time_s;

  // Pin bundle, passed through the synchroniser as one word.
  typedef struct packed {
    logic       xtal;
    logic       cs;
    logic       stb;
    logic       sclk;
    logic       din;
    logic       drive_en;
    logic [2:0] cmd;
  } scc_pins_s;

  // Values after reset.
  localparam logic        SCC_RUN_RST  = 1'b1;
  localparam scc_regcmd_e SCC_REGC_RST = SCC_REG_HOLD;
  localparam scc_tpcmd_e  SCC_TPC_RST  = SCC_TP_64;
  localparam scc_time_s   SCC_TIME_RST = '{month: 4'h1, date: 8'h01, wday: 4'h0,
                                           hour: 8'h00, min: 8'h00, sec: 8'h00};

  // One step of a two-digit BCD count.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Last date of a month; with no year count February always has 28 days.
  function automatic logic [7:0] month_days(input logic [3:0] m);
    case (m)
      4'h2:                   month_days = 8'h28;
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 8'h30;
      default:                month_days = 8'h31;
    endcase
  endfunction

endpackage

// ==== hdl/scc_sync.sv ====
// Purpose: Two-stage synchroniser for the pin bundle.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module scc_sync
  import scc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      ce_i,
  input  wire scc_pins_s d_i,
  output scc_pins_s      q_o
);

  scc_pins_s meta_reg;
  scc_pins_s meta_next;
  scc_pins_s sync_reg;
  scc_pins_s sync_next;

  // Both stages hold while the clock enable is low.
  always_comb
  begin
    meta_next = ce_i ? d_i : meta_reg;
    sync_next = ce_i ? meta_reg : sync_reg;
  end

  // Registers only.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign q_o = sync_reg;

endmodule

// ==== hdl/scc_calendar.sv ====
// Purpose: Seconds to month counters in BCD, month in hex.
// Assumes: tick_i is a one-cycle pulse, at most one per cycle.
// Notes:   A load wins over a tick in the same cycle.
`timescale 1ns/1ps
module scc_calendar
  import scc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      ce_i,
  input  wire logic      tick_i,
  input  wire logic      load_i,
  input  wire scc_time_s load_val_i,
  output scc_time_s      time_o
);

  scc_time_s time_reg;
  scc_time_s time_next;

  // Carry ripples from seconds up to month; each field wraps at its own end.
  always_comb
  begin
    time_next = time_reg;
    if (load_i)
      time_next = load_val_i;
    else if (tick_i)
    begin
      time_next.sec = bcd_inc(time_reg.sec);
      if (time_reg.sec == 8'h59)
      begin
        time_next.sec = 8'h00;
        time_next.min = bcd_inc(time_reg.min);
        if (time_reg.min == 8'h59)
        begin
          time_next.min  = 8'h00;
          time_next.hour = bcd_inc(time_reg.hour);
          if (time_reg.hour == 8'h23)
          begin
            time_next.hour = 8'h00;
            time_next.wday = (time_reg.wday == 4'h6) ? 4'h0 : time_reg.wday + 4'h1;
            time_next.date = bcd_inc(time_reg.date);
            if (time_reg.date >= month_days(time_reg.month))
            begin
              time_next.date  = 8'h01;
              time_next.month = (time_reg.month >= 4'hC) ? 4'h1 : time_reg.month + 4'h1;
            end
          end
        end
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      time_reg <= SCC_TIME_RST;
    else if (ce_i)
      time_reg <= time_next;
  end

  assign time_o = time_reg;

endmodule

// ==== hdl/scc_top.sv ====
// Purpose: Serial calendar clock with a command latch, a 40-bit shift register,
//          a timing pulse output and a Wishbone view of its state.
// Assumes: All pins, the crystal included, are asynchronous to clk_i.
// Notes:   Pin events are seen two to three clocks after they happen.
// How it works
// [R1] Time derives from 32.768 kHz crystal edges.
// [R2] Counters run alone: seconds up to month.
// [R3] Hours wrap at 24; month lengths handled.
// [R4] Digits are BCD, month is hex.
// [R5] Forty-bit shift register moves with shift clock.
// [R6] Pulse output at 64, 256 or 2048 Hz.
// [R7] Top code bit selects register or pulse group.
// [R8] Host drives a three-bit command code.
// [R9] Strobe latches code; held until same-group replacement.
// [R10] Deselected unit ignores shift clock and strobe.
// [R11] Drive enable low floats data out only.
// [R12] Shared lines need a select per device.
// [R13] Rising shift edge samples input and advances.
`timescale 1ns/1ps
module scc_top
  import scc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        xtal_i,
  input  wire logic        chip_select_i,
  input  wire logic        command_latch_strobe_i,
  input  wire logic        shift_clock_i,
  input  wire logic        serial_data_i,
  input  wire logic [2:0]  command_code_i,
  input  wire logic        serial_drive_enable_i,
  output logic             serial_data_o,
  output logic             serial_data_oe_n_o,
  output logic             timing_pulse_out_o
);

  scc_pins_s   pins_raw;
  scc_pins_s   pins;
  scc_time_s   cal_time;
  logic [2:0]  prev_reg;
  logic [2:0]  prev_next;
  logic [14:0] pre_reg;
  logic [14:0] pre_next;
  logic        tp_reg;
  logic        tp_next;
  logic        run_reg;
  logic        run_next;
  scc_regcmd_e regc_reg;
  scc_regcmd_e regc_next;
  scc_tpcmd_e  tpc_reg;
  scc_tpcmd_e  tpc_next;
  logic [39:0] sr_reg;
  logic [39:0] sr_next;
  logic        oen_reg;
  logic        oen_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        xtal_rise;
  logic        stb_rise;
  logic        sclk_rise;
  logic        cmd_take;
  logic        shift_go;
  logic        cal_load;
  logic        sec_tick;
  logic        wb_req;

  // All pins cross into the clk_i domain together.
  assign pins_raw = '{xtal: xtal_i, cs: chip_select_i, stb: command_latch_strobe_i,
                      sclk: shift_clock_i, din: serial_data_i,
                      drive_en: serial_drive_enable_i, cmd: command_code_i};

  scc_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pins_raw),
    .q_o   (pins)
  );

  // Edges are found on the synchronised copies only.
  assign xtal_rise = pins.xtal & ~prev_reg[2];
  assign stb_rise  = pins.stb  & ~prev_reg[1];
  assign sclk_rise = pins.sclk & ~prev_reg[0];

  // [R10] select gates strobe
  assign cmd_take = stb_rise & pins.cs;
  // [R13] rising shift edge
  assign shift_go = sclk_rise & pins.cs & (regc_reg == SCC_REG_SHIFT);
  assign cal_load = cmd_take & (pins.cmd == {1'b0, SCC_REG_SET});

  // [R1] crystal edge timebase
  // The test command speeds the counters to one step per crystal edge, so a
  // whole calendar can be walked in a short simulation.
  assign sec_tick = run_reg & xtal_rise &
                    ((pre_reg == SCC_PRE_LAST) | (tpc_reg == SCC_TP_TEST));

  // [R2] independent counters
  scc_calendar u_cal (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .tick_i     (sec_tick),
    .load_i     (cal_load),
    .load_val_i (sr_reg),
    .time_o     (cal_time)
  );

  // Timebase group: edge history, prescaler and pulse output.
  always_comb
  begin
    prev_next = {pins.xtal, pins.stb, pins.sclk};
    pre_next  = pre_reg;
    if (cal_load)
      pre_next = '0;
    else if (xtal_rise)
      pre_next = pre_reg + 15'h0001;
    // [R6] pulse rate select
    case (tpc_reg)
      SCC_TP_64:  tp_next = pre_reg[SCC_TP64_BIT];
      SCC_TP_256: tp_next = pre_reg[SCC_TP256_BIT];
      default:    tp_next = pre_reg[SCC_TP2048_BIT];
    endcase
  end

  // Registers only.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_reg <= 3'h0;
      pre_reg  <= 15'h0000;
      tp_reg   <= 1'b0;
    end
    else if (ce_i)
    begin
      prev_reg <= prev_next;
      pre_reg  <= pre_next;
      tp_reg   <= tp_next;
    end
  end

  // Command group: latches, shift register and output drive.
  always_comb
  begin
    regc_next = regc_reg;
    tpc_next  = tpc_reg;
    sr_next   = sr_reg;
    // [R11] drive enable alone
    oen_next  = ~pins.drive_en;
    // [R7] group by top bit
    if (cmd_take)
    begin
      // [R9] latch per group
      if (pins.cmd[2])
        tpc_next = scc_tpcmd_e'(pins.cmd[1:0]);
      else
        regc_next = scc_regcmd_e'(pins.cmd[1:0]);
    end
    // [R4] BCD time word
    // A read command copies the live time into the shift register.
    if (cmd_take & (pins.cmd == {1'b0, SCC_REG_READ}))
      sr_next = cal_time;
    // [R5] forty-bit shift
    else if (shift_go)
      sr_next = {pins.din, sr_reg[39:1]};
  end

  // Registers only.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      regc_reg <= SCC_REGC_RST;
      tpc_reg  <= SCC_TPC_RST;
      sr_reg   <= SCC_TIME_RST;
      oen_reg  <= 1'b1;
    end
    else if (ce_i)
    begin
      regc_reg <= regc_next;
      tpc_reg  <= tpc_next;
      sr_reg   <= sr_next;
      oen_reg  <= oen_next;
    end
  end

  // Wishbone slave: answers every request one cycle later, unmapped as zero.
  // A write lands only at the edge that samples ack high, where the master
  // still holds its request, so the run bit never changes ahead of the answer.
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;

  always_comb
  begin
    ack_next = wb_req;
    run_next = run_reg;
    dat_next = 32'h0000_0000;
    if (ack_reg & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i == SCC_ADR_CTRL))
      run_next = wb_dat_i[0];
    if (wb_req & ~wb_we_i)
    begin
      case (wb_adr_i)
        SCC_ADR_CTRL:    dat_next = {31'h0, run_reg};
        SCC_ADR_TIME_LO: dat_next = {4'h0, cal_time[27:0]};
        SCC_ADR_TIME_HI: dat_next = {20'h0, cal_time[39:28]};
        SCC_ADR_STATUS:  dat_next = {27'h0, pins.cs, tpc_reg, regc_reg};
        default:         dat_next = 32'h0000_0000;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      run_reg <= SCC_RUN_RST;
      dat_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_reg <= ack_next;
      run_reg <= run_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o           = ack_reg;
  assign wb_dat_o           = dat_reg;
  assign serial_data_o      = sr_reg[0];
  assign serial_data_oe_n_o = oen_reg;
  assign timing_pulse_out_o = tp_reg;

  // Checks; a low clock enable aborts any check in flight.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i | ~ce_i);

  sequence s_wb_req;
    wb_cyc_i & wb_stb_i & ~wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 ~wb_ack_o;
  endsequence

  a_wb_answer_once: assert property (s_wb_req |=> s_ack_pulse)
    else $error("Wishbone answer missing or held too long.");

  a_shift_step_in: assert property ( // [R13]
    shift_go & ~cmd_take |=> sr_reg == {$past(pins.din), $past(sr_reg[39:1])})
    else $error("Shift register did not advance on a shift edge.");

  a_deselect_ignore: assert property ( // [R10]
    ~pins.cs |=> $stable(regc_reg) & $stable(tpc_reg) & $stable(sr_reg))
    else $error("Deselected unit reacted to its strobe or shift clock.");

  a_reg_group_latch: assert property ( // [R9]
    cmd_take & ~pins.cmd[2] |=> regc_reg == $past(pins.cmd[1:0]) & $stable(tpc_reg))
    else $error("Register group command not latched alone.");

  a_tp_group_latch: assert property ( // [R7]
    cmd_take & pins.cmd[2] |=> tpc_reg == $past(pins.cmd[1:0]) & $stable(regc_reg))
    else $error("Pulse group command not latched alone.");

  a_drive_float: assert property ( // [R11]
    ~pins.drive_en |=> serial_data_oe_n_o)
    else $error("Data output driven while drive enable is low.");

  a_hour_wrap_24: assert property ( // [R3]
    sec_tick & ~cal_load & (cal_time[23:0] == 24'h235959) |=> cal_time.hour == 8'h00)
    else $error("Hour counter did not wrap after 23:59:59.");

  a_pulse_rate_64: assert property ( // [R6]
    tpc_reg == SCC_TP_64 ##1 tpc_reg == SCC_TP_64 |-> tp_reg == $past(pre_reg[8]))
    else $error("Timing pulse does not follow the 64 Hz divider.");

  a_time_set_load: assert property ( // [R5]
    cal_load |=> cal_time == $past(sr_reg) & pre_reg == 15'h0000)
    else $error("Time set did not copy the shift register.");

  a_second_step: assert property ( // [R2]
    sec_tick & ~cal_load & (cal_time.sec != 8'h59)
      |=> cal_time.sec == bcd_inc($past(cal_time.sec)))
    else $error("Seconds did not step on a second tick.");

  // A control write with its low lane enabled lands with the answer.
  a_ctrl_write_ack: assert property (
    wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i == SCC_ADR_CTRL)
      |=> run_reg == $past(wb_dat_i[0]))
    else $error("Control write did not land with its answer.");

endmodule

// ==== testbench/scc_host_model.sv ====
// Purpose: Host model that drives the command, strobe, shift clock and crystal pins.
// Assumes: Pins change just after a rising clk_i edge and rest at least three cycles.
// Notes:   The shift clock rests low between frames, and the data input is inverted after one.
`timescale 1ns/1ps
module scc_host_model (
  input  wire logic       clk_i,
  input  wire logic       data_line_i,
  output logic            xtal_o,
  output logic            cs_o,
  output logic            stb_o,
  output logic            sclk_o,
  output logic            din_o,
  output logic            den_o,
  output logic [2:0]      cmd_o
);
  // Idle levels at time zero.
  initial
  begin
    xtal_o = 1'b0;
    cs_o = 1'b1;
    stb_o = 1'b0;
    sclk_o = 1'b0;
    din_o = 1'b0;
    den_o = 1'b1;
    cmd_o = 3'h0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic pins(input logic c, input logic d);
    cs_o <= c;
    den_o <= d;
    hold(4);
  endtask

  task automatic command(input logic [2:0] c);
    cmd_o <= c;
    hold(4);
    stb_o <= 1'b1;
    hold(4);
    stb_o <= 1'b0;
    hold(4);
  endtask

  task automatic shift(input logic b, output logic q);
    din_o <= b;
    hold(4);
    q = data_line_i;
    sclk_o <= 1'b1;
    hold(4);
    sclk_o <= 1'b0;
  endtask

  // Forty bits, low bit first; the released input is inverted so no stale bit survives.
  task automatic frame(input logic [39:0] w, output logic [39:0] r);
    logic b;
    for (int i = 0; i < 40; i++)
    begin
      shift(w[i], b);
      r[i] = b;
    end
    din_o <= ~din_o;
  endtask

  // Crystal edges on demand, so counts stay exact.
  task automatic pulses(input int n);
    repeat (n)
    begin
      xtal_o <= 1'b1;
      hold(3);
      xtal_o <= 1'b0;
      hold(3);
    end
    hold(6);
  endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the serial calendar clock.
// Assumes: Weekday wraps from 6 to 0 and test mode steps seconds on each crystal edge.
// Notes:   The crystal only pulses on request, so no second passes by itself.
`timescale 1ns/1ps
module testbench;
  import scc_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, sdo, oe_n, tp, ack, ce;
  logic [3:0]  sel, wsel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [39:0] old, rd;
  wire         xt, cs, sb, sk, di, de, line;
  wire  [2:0]  cmd;
  int          s, mi, h, wd, dt, mo, p, b, fail_count, check_count, cycles;

  // The bench forms the three-state data line.
  assign line = oe_n ? 1'bz : sdo;

  scc_top i_scc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .xtal_i(xt), .chip_select_i(cs),
    .command_latch_strobe_i(sb), .shift_clock_i(sk), .serial_data_i(di),
    .command_code_i(cmd), .serial_drive_enable_i(de), .serial_data_o(sdo),
    .serial_data_oe_n_o(oe_n), .timing_pulse_out_o(tp));

  scc_host_model i_scc_host_model (.clk_i(clk_i), .data_line_i(line), .xtal_o(xt),
    .cs_o(cs), .stb_o(sb), .sclk_o(sk), .din_o(di), .den_o(de), .cmd_o(cmd));

  function automatic logic [7:0] b2(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  function automatic int mlen(input int m);
    return (m == 2) ? 28 : ((m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31);
  endfunction

  function automatic logic [39:0] word();
    return {4'(mo), b2(dt), 4'(wd), b2(h), b2(mi), b2(s)};
  endfunction

  // One second of the reference calendar, carries rippling upward.
  task automatic tick();
    s = (s + 1) % 60;
    if (s == 0) mi = (mi + 1) % 60;
    if (s + mi == 0) h = (h + 1) % 24;
    if (s + mi + h == 0) wd = (wd + 1) % 7;
    if (s + mi + h == 0) dt = dt % mlen(mo) + 1;
    if (s + mi + h == 0 && dt == 1) mo = mo % 12 + 1;
  endtask

  task automatic chk(input string n, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Classic single cycle: hold everything until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdtime();
    wb(1'b0, SCC_ADR_TIME_LO, 32'h0);
    old = 40'(q[27:0]);
    wb(1'b0, SCC_ADR_TIME_HI, 32'h0);
    chk("time", {q[11:0], old[27:0]}, word());
  endtask

  task automatic stat(input int r, input int t);
    wb(1'b0, SCC_ADR_STATUS, 32'h0);
    // Select is high at every status read, so bit 4 is expected set.
    chk("status", 40'(q[4:0]), 40'(16 + t * 4 + r));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // A hang ends the run with a counted mismatch.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  // Main sequence: reset view, pulse rates, serial set and read, select and drive enable.
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    ce = 1'b1;
    sel = 4'hF;
    wsel = 4'hF;
    {s, mi, h, wd, p} = '0;
    {dt, mo} = {32'd1, 32'd1};
    b = $urandom(32'h436d);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    // A control write without its low lane must leave the run bit alone.
    wsel = 4'hE;
    wb(1'b1, SCC_ADR_CTRL, 32'h0);
    wsel = 4'hF;
    wb(1'b0, SCC_ADR_CTRL, 32'h0);
    chk("ctrl", 40'(q), 40'h1);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 40'(q), 40'h0);
    wb(1'b1, SCC_ADR_TIME_LO, 32'hFFFFFFFF);
    rdtime();
    for (int k = 0; k < 3; k++)
    begin
      b = (k == 0) ? SCC_TP64_BIT : ((k == 1) ? SCC_TP256_BIT : SCC_TP2048_BIT);
      i_scc_host_model.command(3'(4 + k));
      stat(0, k);
      repeat (2)
      begin
        i_scc_host_model.pulses(1 << b);
        p += 1 << b;
        chk("pulse", 40'(tp), 40'((p >> b) & 1));
      end
    end
    for (int t = 0; t < 3; t++)
    begin
      old = word();
      s = 57 + $urandom % 3;
      // The first pass always crosses midnight at the end of the year.
      mi = (t == 0 || $urandom % 2) ? 59 : $urandom % 60;
      h = (t == 0 || $urandom % 2) ? 23 : $urandom % 24;
      mo = (t == 0) ? 12 : 1 + $urandom % 12;
      dt = (t == 0 || $urandom % 2) ? mlen(mo) : 1 + $urandom % mlen(mo);
      wd = $urandom % 7;
      i_scc_host_model.command(3'd3);
      i_scc_host_model.command(3'd1);
      i_scc_host_model.frame(word(), rd);
      chk("serial out", rd, old);
      i_scc_host_model.command(3'd2);
      rdtime();
      i_scc_host_model.command(3'd7);
      stat(2, 3);
      i_scc_host_model.pulses(3);
      repeat (3) tick();
      rdtime();
    end
    wb(1'b1, SCC_ADR_CTRL, 32'h0);
    i_scc_host_model.pulses(3);
    rdtime();
    wb(1'b1, SCC_ADR_CTRL, 32'h1);
    // With the clock enable low the crystal edges are lost, so time stands.
    ce <= 1'b0;
    i_scc_host_model.pulses(3);
    ce <= 1'b1;
    rdtime();
    i_scc_host_model.pins(1'b1, 1'b0);
    chk("float", 40'(oe_n), 40'h1);
    i_scc_host_model.pins(1'b1, 1'b1);
    chk("drive", 40'(oe_n), 40'h0);
    i_scc_host_model.command(3'd3);
    i_scc_host_model.command(3'd1);
    i_scc_host_model.pins(1'b0, 1'b1);
    i_scc_host_model.command(3'd2);
    i_scc_host_model.frame(40'hA5A5A5A5A5, rd);
    i_scc_host_model.pins(1'b1, 1'b1);
    stat(1, 3);
    i_scc_host_model.frame(40'h0, rd);
    chk("deselected", rd, word());
    // The hold command keeps the shift register still under shift clocks.
    i_scc_host_model.command(3'd3);
    i_scc_host_model.command(3'd0);
    stat(0, 3);
    old = word();
    i_scc_host_model.frame(~old, rd);
    chk("hold", rd, {40{old[0]}});
    // A reset in mid-run returns calendar and command latches to start.
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    {s, mi, h, wd, dt, mo} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd1, 32'd1};
    repeat (3) @(posedge clk_i);
    rdtime();
    stat(0, 0);
    give_verdict();
  end
endmodule
